// file: core/fce_pkg.sv
package fce_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_WDATA = 8'h08;
    localparam logic [7:0] ADDR_RDATA = 8'h0C;
    localparam logic [7:0] ADDR_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_HALF = 8'h14;
    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int CTRL_FT_BIT = 0;
    localparam int CTRL_RESET_BIT = 1;
    localparam logic CTRL_FT_RESET = 1'b1;
    // ----------------------------------------
    // Status fields
    // ----------------------------------------
    localparam int ST_EMPTY_N = 0;
    localparam int ST_FULL_N = 1;
    localparam int ST_OUT_VALID_N = 2;
    localparam int ST_ROOM_N = 3;
    localparam int ST_HALF = 4;
    localparam int ST_FT = 5;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int DATA_W = 36;
    localparam int FIFO_DEPTH = 16;
    localparam logic [31:0] HALF_RESET = 32'h00000008;
endpackage

// file: core/fce_fifo.sv
`timescale 1ns/1ns
`default_nettype none
// FIFO with valid/ready both sides
module fce_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    // Fill level
    output logic [$clog2(DEPTH):0] count_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic push;
    logic pop;

    // Handshakes
    assign in_ready_out = (count_out != DEPTH[AW:0]);
    assign out_valid_out = (count_out != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr];

    // Storage
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count_out <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count_out <= count_out + 1'b1;
            end else if (pop && !push) begin
                count_out <= count_out - 1'b1;
            end
        end
    end
endmodule // fce_fifo
`default_nettype wire

// file: core/fce_stage.sv
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fce_stage #(
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RESET_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Upstream chain port
    input wire logic [35:0] CHAIN_DATA_IN,
    input wire logic CHAIN_WRITE_N_IN,
    output logic WRITE_ROOM_FLAG_N_OUT,
    output logic FULL_INDICATOR_N_OUT,
    // Downstream chain port
    output logic [35:0] CHAIN_DATA_OUT,
    input wire logic CHAIN_READ_N_IN,
    output logic READ_VALID_FLAG_N_OUT,
    output logic EMPTY_INDICATOR_N_OUT,
    // Status
    output logic HALF_FULL_OUT
);
    localparam int CW = $clog2(DEPTH) + 1;
    typedef enum logic [1:0] {FCE_IDLE, FCE_ACCESS} fce_state_e;

    fce_state_e bus_state;
    logic fall_through_timing;
    logic [31:0] half_level;
    logic [35:0] wdata_hold;
    logic apb_push;
    logic out_valid;
    logic [35:0] out_data;
    logic fifo_ready;
    logic [CW-1:0] level;
    logic [CW-1:0] next_level;
    logic wr_sync1, wr_sync2, wr_sync3;
    logic rd_sync1, rd_sync2, rd_sync3;
    logic [35:0] din_q;
    logic chain_write;
    logic chain_read;
    logic bus_pop;
    logic push_valid;
    logic [35:0] push_data;
    logic pop;
    logic setup;
    logic access;

    // Register map decode
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == fce_pkg::ADDR_CTRL) || (addr == fce_pkg::ADDR_STATUS) ||
            (addr == fce_pkg::ADDR_WDATA) || (addr == fce_pkg::ADDR_RDATA) ||
            (addr == fce_pkg::ADDR_LEVEL) || (addr == fce_pkg::ADDR_HALF);
    endfunction

    // ----------------------------------------
    // Pin input synchronisers
    // ----------------------------------------
    // Three stages; a low level counts when second and third agree
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            wr_sync1 <= 1'b1;
            wr_sync2 <= 1'b1;
            wr_sync3 <= 1'b1;
            rd_sync1 <= 1'b1;
            rd_sync2 <= 1'b1;
            rd_sync3 <= 1'b1;
            din_q <= '0;
        end else begin
            wr_sync1 <= CHAIN_WRITE_N_IN;
            wr_sync2 <= wr_sync1;
            wr_sync3 <= wr_sync2;
            rd_sync1 <= CHAIN_READ_N_IN;
            rd_sync2 <= rd_sync1;
            rd_sync3 <= rd_sync2;
            din_q <= CHAIN_DATA_IN;
        end
    end

    // Active-low enables, agreed by second and third stage
    assign chain_write = !wr_sync2 && !wr_sync3 && fall_through_timing;
    assign chain_read = !rd_sync2 && !rd_sync3 && fall_through_timing;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign setup = PSEL_IN && !PENABLE_IN;
    assign access = PSEL_IN && PENABLE_IN && PREADY_OUT;
    assign apb_push = access && PWRITE_IN && (PADDR_IN == fce_pkg::ADDR_WDATA);
    assign bus_pop = access && !PWRITE_IN && (PADDR_IN == fce_pkg::ADDR_RDATA);

    // Access tracking; ready in first access cycle, no wait state
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            bus_state <= FCE_IDLE;
            PREADY_OUT <= 1'b0;
        end else begin
            case (bus_state)
                FCE_IDLE: begin
                    PREADY_OUT <= 1'b0;
                    if (setup) begin
                        bus_state <= FCE_ACCESS;
                        PREADY_OUT <= 1'b1;
                    end
                end
                FCE_ACCESS: begin
                    bus_state <= FCE_IDLE;
                    PREADY_OUT <= 1'b0;
                end
                default: begin
                    bus_state <= FCE_IDLE;
                    PREADY_OUT <= 1'b0;
                end
            endcase
        end
    end

    // Read data and error, computed in setup cycle
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            PRDATA_OUT <= '0;
            PSLVERR_OUT <= 1'b0;
        end else if (setup) begin
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= '0;
            case (PADDR_IN)
                fce_pkg::ADDR_CTRL: PRDATA_OUT[fce_pkg::CTRL_FT_BIT] <= fall_through_timing;
                fce_pkg::ADDR_STATUS: begin
                    PRDATA_OUT[fce_pkg::ST_EMPTY_N] <= EMPTY_INDICATOR_N_OUT;
                    PRDATA_OUT[fce_pkg::ST_FULL_N] <= FULL_INDICATOR_N_OUT;
                    PRDATA_OUT[fce_pkg::ST_OUT_VALID_N] <= READ_VALID_FLAG_N_OUT;
                    PRDATA_OUT[fce_pkg::ST_ROOM_N] <= WRITE_ROOM_FLAG_N_OUT;
                    PRDATA_OUT[fce_pkg::ST_HALF] <= HALF_FULL_OUT;
                    PRDATA_OUT[fce_pkg::ST_FT] <= fall_through_timing;
                end
                fce_pkg::ADDR_WDATA: PRDATA_OUT <= wdata_hold[31:0];
                fce_pkg::ADDR_RDATA: PRDATA_OUT <= out_data[31:0];
                fce_pkg::ADDR_LEVEL: PRDATA_OUT <= {{(32 - CW){1'b0}}, level};
                fce_pkg::ADDR_HALF: PRDATA_OUT <= half_level;
                default: PSLVERR_OUT <= 1'b1;
            endcase
        end
    end

    // Control, half-level and write-data registers; mode taken on any write to CTRL
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            fall_through_timing <= fce_pkg::CTRL_FT_RESET;
            half_level <= fce_pkg::HALF_RESET;
            wdata_hold <= '0;
        end else if (access && PWRITE_IN) begin
            if (PADDR_IN == fce_pkg::ADDR_CTRL) begin
                fall_through_timing <= PWDATA_IN[fce_pkg::CTRL_FT_BIT];
            end
            if (PADDR_IN == fce_pkg::ADDR_HALF) begin
                half_level <= PWDATA_IN;
            end
            if (PADDR_IN == fce_pkg::ADDR_WDATA) begin
                wdata_hold <= {4'h0, PWDATA_IN};
            end
        end
    end

    // ----------------------------------------
    // Storage and chain datapath
    // ----------------------------------------
    // Chain writes take priority; bus write refused while chained
    assign push_valid = chain_write || (apb_push && !fall_through_timing);
    assign push_data = chain_write ? din_q : {4'h0, PWDATA_IN};
    assign pop = out_valid && (chain_read || bus_pop);

    fce_fifo #(
        .WIDTH(fce_pkg::DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_in(CORE_CLK_IN),
        .rst_in(RESET_IN),
        .in_valid_in(push_valid),
        .in_ready_out(fifo_ready),
        .in_data_in(push_data),
        .out_valid_out(out_valid),
        .out_ready_in(chain_read || bus_pop),
        .out_data_out(out_data),
        .count_out(level)
    );

    assign next_level = level;

    // Flags and output data, straight from flip-flops
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            READ_VALID_FLAG_N_OUT <= 1'b1;
            WRITE_ROOM_FLAG_N_OUT <= 1'b1;
            EMPTY_INDICATOR_N_OUT <= 1'b0;
            FULL_INDICATOR_N_OUT <= 1'b1;
            HALF_FULL_OUT <= 1'b0;
            CHAIN_DATA_OUT <= '0;
        end else begin
            // Word on outputs drives valid low one clock later, no read needed
            READ_VALID_FLAG_N_OUT <= !out_valid;
            CHAIN_DATA_OUT <= out_data;
            // Free slot drives room low for the upstream stage
            WRITE_ROOM_FLAG_N_OUT <= !fifo_ready;
            EMPTY_INDICATOR_N_OUT <= out_valid;
            FULL_INDICATOR_N_OUT <= fifo_ready;
            // Half-full usable from any single device
            HALF_FULL_OUT <= ({{(32 - CW){1'b0}}, next_level} >= half_level);
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_valid_follows;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        out_valid |=> !READ_VALID_FLAG_N_OUT;
    endproperty
    a_valid_follows: assert property (p_valid_follows) else $error("valid flag late");

    property p_empty_high;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        !out_valid |=> READ_VALID_FLAG_N_OUT && !EMPTY_INDICATOR_N_OUT;
    endproperty
    a_empty_high: assert property (p_empty_high) else $error("empty flags wrong");

    property p_ripple;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (level == '0 && push_valid) |=> ##1 !READ_VALID_FLAG_N_OUT;
    endproperty
    a_ripple: assert property (p_ripple) else $error("ripple delay wrong");

    property p_room;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (level == DEPTH[CW-1:0] && pop) |=> ##1 !WRITE_ROOM_FLAG_N_OUT;
    endproperty
    a_room: assert property (p_room) else $error("room flag late");

    property p_full;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (level == DEPTH[CW-1:0]) |=> WRITE_ROOM_FLAG_N_OUT && !FULL_INDICATOR_N_OUT;
    endproperty
    a_full: assert property (p_full) else $error("full flags wrong");

    property p_data;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        out_valid |=> CHAIN_DATA_OUT == $past(out_data);
    endproperty
    a_data: assert property (p_data) else $error("chain data mismatch");

    property p_stream;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (out_valid && pop && level > 1) |=> !READ_VALID_FLAG_N_OUT;
    endproperty
    a_stream: assert property (p_stream) else $error("later word delayed");

    property p_ready;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        setup |=> PREADY_OUT ##1 !PREADY_OUT;
    endproperty
    a_ready: assert property (p_ready) else $error("apb ready timing");

    property p_half;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        ({{(32 - CW){1'b0}}, level} >= half_level) |=> HALF_FULL_OUT;
    endproperty
    a_half: assert property (p_half) else $error("half flag wrong");

    property p_cov_fill;
        @(posedge CORE_CLK_IN) level == DEPTH[CW-1:0];
    endproperty
    c_cov_fill: cover property (p_cov_fill);

    property p_cov_chain;
        @(posedge CORE_CLK_IN) chain_write && chain_read;
    endproperty
    c_cov_chain: cover property (p_cov_chain);

    property p_cov_bus;
        @(posedge CORE_CLK_IN) bus_pop && out_valid;
    endproperty
    c_cov_bus: cover property (p_cov_bus);

    // Unmapped offsets answer with an error, mapped ones without
    property p_slverr;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (setup && !is_mapped(PADDR_IN)) |=> PSLVERR_OUT && PREADY_OUT;
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped access not refused");

    property p_slverr_clear;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (setup && is_mapped(PADDR_IN)) |=> !PSLVERR_OUT;
    endproperty
    a_slverr_clear: assert property (p_slverr_clear) else $error("error on mapped access");

    // Ready only answers a setup cycle
    property p_ready_low;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (bus_state == FCE_IDLE && !setup) |=> !PREADY_OUT;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready without setup");

    // Chain owns the input while chained; bus word leaves level alone
    property p_bus_refused;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (apb_push && fall_through_timing && !chain_write && !pop) |=> level == $past(level);
    endproperty
    a_bus_refused: assert property (p_bus_refused) else $error("bus write taken in chain");

    // A full stage drops further words until read
    property p_drop_full;
        @(posedge CORE_CLK_IN) disable iff (RESET_IN)
        (level == DEPTH[CW-1:0] && !pop) |=> level == DEPTH[CW-1:0];
    endproperty
    a_drop_full: assert property (p_drop_full) else $error("level moved while full");

    // ----------------------------------------
    // Further cover points
    // ----------------------------------------
    property p_cov_refuse;
        @(posedge CORE_CLK_IN) apb_push && fall_through_timing;
    endproperty
    c_cov_refuse: cover property (p_cov_refuse);

    property p_cov_half;
        @(posedge CORE_CLK_IN) HALF_FULL_OUT;
    endproperty
    c_cov_half: cover property (p_cov_half);
endmodule // fce_stage
`default_nettype wire

// file: testbench/fce_nbr.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Neighbour stages
// ----
module fce_nbr (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic stall_in,
    // Upstream stage
    input wire logic room_n_in,
    output logic [35:0] data_out,
    output logic write_n_out,
    // Downstream stage
    input wire logic valid_n_in,
    input wire logic [35:0] data_in,
    output logic read_n_out
);
    logic [35:0] got[$];
    int gap;
    // Idle lines at start
    initial begin
        data_out = 36'h000000000;
        write_n_out = 1'b1;
    end
    // Push one word once room shows
    task automatic send(input logic [35:0] w, output bit ok);
        int n;
        for (n = 0; n < 40 && room_n_in !== 1'b0; n++) @(posedge clk_in);
        ok = (n < 40);
        if (ok) begin
            data_out <= w;
            write_n_out <= 1'b0;
            // Low for two samples: the stage counts a level once two sync flops agree
            repeat (2) @(posedge clk_in);
            write_n_out <= 1'b1;
            repeat (5) @(posedge clk_in);
            data_out <= ~w; // Released lines show no stale word
            @(posedge clk_in);
        end
    endtask
    // Take head word while valid shows
    always @(posedge clk_in) begin
        if (rst_in) begin
            read_n_out <= 1'b1;
            gap <= 0;
        end else if (gap > 0) begin
            // Read held low for two samples, one pop at the stage
            read_n_out <= (gap == 8) ? 1'b0 : 1'b1;
            gap <= gap - 1;
        end else if (valid_n_in === 1'b0 && !stall_in) begin
            got.push_back(data_in);
            read_n_out <= 1'b0;
            gap <= 8;
        end
    end
endmodule // fce_nbr
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    // ----
    // Signals and parts
    // ----
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic stall = 1'b1;
    logic [31:0] prdata, q;
    logic pready, pslverr, room_n, full_n, valid_n, empty_n, half, wr_n, rd_n, e;
    logic [35:0] up_data, dn_data;
    bit ok;
    int n_fail = 0;
    int checks_done = 0;
    // Composite flags over the side-by-side set, formed by gates only
    logic comp_empty_n, comp_full_n, comp_valid_n, comp_room_n;
    assign comp_empty_n = &{empty_n};
    assign comp_full_n = &{full_n};
    assign comp_valid_n = |{valid_n};
    assign comp_room_n = |{room_n};
    always #25 clk = ~clk;
    // Controls tied in common; any side-by-side partner shares this depth
    fce_stage #(.DEPTH(fce_pkg::FIFO_DEPTH)) dut (.CORE_CLK_IN(clk), .RESET_IN(rst),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .CHAIN_DATA_IN(up_data), .CHAIN_WRITE_N_IN(wr_n), .WRITE_ROOM_FLAG_N_OUT(room_n),
        .FULL_INDICATOR_N_OUT(full_n), .CHAIN_DATA_OUT(dn_data), .CHAIN_READ_N_IN(rd_n),
        .READ_VALID_FLAG_N_OUT(valid_n), .EMPTY_INDICATOR_N_OUT(empty_n),
        .HALF_FULL_OUT(half));
    fce_nbr nbr (.clk_in(clk), .rst_in(rst), .stall_in(stall), .room_n_in(room_n),
        .data_out(up_data), .write_n_out(wr_n), .valid_n_in(valid_n),
        .data_in(dn_data), .read_n_out(rd_n));
    // ----
    // Shared tasks
    // ----
    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Mismatch report
    task automatic bad(input string m);
        n_fail++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask
    // Word and flag compares
    task automatic chk_w(input logic [35:0] g, input logic [35:0] x, input string m);
        checks_done++;
        if (g !== x) bad(m);
    endtask
    task automatic chk_f(input logic g, input logic x, input string m);
        checks_done++;
        if (g !== x) bad(m);
    endtask
    // One bus transfer, result in q and e
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            bad("bus timeout");
            close_out();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Bounded wait for words at the sink
    task automatic wait_got(input int k);
        int c;
        for (c = 0; c < 400 && nbr.got.size() < k; c++) @(posedge clk);
        if (c == 400) begin
            bad("sink timeout");
            close_out();
        end
    endtask
    // ----
    // Scenarios
    // ----
    // Values after reset, unmapped access
    task automatic t_reset();
        apb(1'b0, fce_pkg::ADDR_STATUS, 32'h00000000);
        chk_w({4'h0, q}, 36'h000000026, "status after reset");
        apb(1'b0, fce_pkg::ADDR_CTRL, 32'h00000000);
        chk_w({4'h0, q}, 36'h000000001, "mode after reset");
        apb(1'b0, fce_pkg::ADDR_HALF, 32'h00000000);
        chk_w({4'h0, q}, {4'h0, fce_pkg::HALF_RESET}, "half level");
        apb(1'b0, 8'hFC, 32'h00000000);
        chk_f(e, 1'b1, "unmapped access");
        chk_f(valid_n, 1'b1, "valid when empty");
    endtask
    // First word falls through with no read
    task automatic t_ripple();
        nbr.send(36'h900000001, ok);
        chk_f(valid_n, 1'b0, "word not at output");
        chk_w(dn_data, 36'h900000001, "output word");
        chk_f(comp_valid_n, 1'b0, "composite valid");
        stall <= 1'b0;
        nbr.send(36'h6FFFFFFFE, ok);
        nbr.send(36'hC3C3C3C3C, ok);
        wait_got(3);
        chk_w(nbr.got[0], 36'h900000001, "word 0");
        chk_w(nbr.got[1], 36'h6FFFFFFFE, "word 1");
        chk_w(nbr.got[2], 36'hC3C3C3C3C, "word 2");
        nbr.got.delete();
    endtask
    // Fill to full, refuse, drain in order
    task automatic t_full();
        int i;
        stall <= 1'b1;
        for (i = 0; i < 16; i++) begin
            nbr.send(36'h100000000 + 36'(i), ok);
            chk_f(ok, 1'b1, "room while filling");
        end
        chk_f(full_n, 1'b0, "full flag");
        chk_f(half, 1'b1, "half flag");
        chk_f(comp_room_n, 1'b1, "composite room when full");
        nbr.send(36'h0DEADBEEF, ok);
        chk_f(ok, 1'b0, "room when full");
        stall <= 1'b0;
        for (i = 0; i < 20 && room_n !== 1'b0; i++) @(posedge clk);
        chk_f(i < 20, 1'b1, "room after read");
        wait_got(16);
        for (i = 0; i < 16; i++) chk_w(nbr.got[i], 36'h100000000 + 36'(i), "drain");
        repeat (8) @(posedge clk);
        chk_f(empty_n, 1'b0, "empty after drain");
        nbr.got.delete();
    endtask
    // Bus path and mode switch
    task automatic t_bus();
        stall <= 1'b1;
        apb(1'b1, fce_pkg::ADDR_WDATA, 32'h12345678);
        repeat (4) @(posedge clk);
        apb(1'b0, fce_pkg::ADDR_LEVEL, 32'h00000000);
        chk_w({4'h0, q}, 36'h000000000, "bus write in chain mode");
        apb(1'b1, fce_pkg::ADDR_CTRL, 32'h00000000);
        apb(1'b1, fce_pkg::ADDR_WDATA, 32'hF00D0042);
        repeat (6) @(posedge clk);
        chk_f(comp_empty_n, 1'b1, "composite empty");
        chk_f(comp_full_n, 1'b1, "composite full");
        apb(1'b1, fce_pkg::ADDR_HALF, 32'h00000001);
        repeat (2) @(posedge clk);
        chk_f(half, 1'b1, "half at new threshold");
        apb(1'b1, fce_pkg::ADDR_HALF, fce_pkg::HALF_RESET);
        apb(1'b0, fce_pkg::ADDR_RDATA, 32'h00000000);
        chk_w({4'h0, q}, 36'h0F00D0042, "bus read word");
        apb(1'b0, fce_pkg::ADDR_STATUS, 32'h00000000);
        chk_f(q[fce_pkg::ST_FT], 1'b0, "mode bit");
        apb(1'b1, fce_pkg::ADDR_CTRL, 32'h00000001);
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_ripple();
        t_full();
        t_bus();
        close_out();
    end
endmodule // tb
`default_nettype wire
